// ### verilog/pcm_config_regs.sv
// Class and miscellaneous configuration words of the first PCI port, plus the
// master read command choice and latency timer that these words steer.
// Assumes config and processor-bus strobes are one-cycle pulses, synchronous to clock.
//
// Behaviour
// R1: Base class resets to bridge 0x06; controller mode loads 0x0E.
// R2: Sub class resets to 0x80; controller mode holds 0x00.
// R3: Programming interface resets to zero; value one maps queues at 0x40/0x44.
// R4: Controller value one also maps interrupt status/mask at 0x30/0x34.
// R5: Class word fields change only from processor bus or EEPROM load.
// R6: Self-test capable, start and completion code always read zero.
// R7: Multifunction bit and seven-bit header layout read zero.
// R8: Latency timer counts PCI clocks; expiry starts master termination.
// R9: Latency timer never shorter than eight clocks; 0-7 act as eight.
// R10: Cacheline codes 0x04, 0x08, 0x10, 0x20 give 4, 8, 16, 32 words.
// R11: Any other cacheline code, including 0x00, means eight words.
// R12: Read under 8 bytes Memory Read; up to line Line; else Multiple.
// R13: Port reset restores all fields; EEPROM load then overwrites defaults.
// R14: Revision is eight bits in the class word's low byte, PCI readable.
`timescale 1ns/1ps
module pcm_config_regs (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic pb_wr,
  input wire logic pb_rd,
  input wire logic [7:0] pb_addr,
  input wire logic [3:0] pb_be,
  input wire logic [31:0] pb_wdata,
  output logic [31:0] pb_rdata,
  input wire logic ee_load,
  input wire logic [31:0] ee_class_word,
  input wire logic mst_req,
  input wire logic [15:0] mst_read_bytes,
  output logic [3:0] mst_read_cmd,
  input wire logic mst_owner,
  output logic mst_lt_expired,
  output logic [5:0] cacheline_words,
  output logic controller_mode
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] base_reg;
  logic [7:0] sub_reg;
  logic [7:0] programming_interface_field_reg;
  logic [7:0] rev_reg;
  logic [7:0] master_latency_timer_reg;
  logic [7:0] cacheline_size_field_reg;
  logic [31:0] class_word;
  logic [31:0] misc_word;
  logic cfg_hit_misc;
  logic pb_hit_class;
  logic pb_hit_misc;

  assign cfg_hit_misc = cfg_wr && (cfg_addr == pcm_pkg::MISC_WORD_OFS);
  assign pb_hit_class = pb_wr && (pb_addr == pcm_pkg::CLASS_WORD_OFS);
  assign pb_hit_misc = pb_wr && (pb_addr == pcm_pkg::MISC_WORD_OFS);

  // Class word: PCI writes are ignored; a processor write beats an EEPROM load
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      base_reg <= pcm_pkg::BASE_BRIDGE; // see R1
      sub_reg <= pcm_pkg::SUB_OTHER_BRIDGE; // see R2
      programming_interface_field_reg <= pcm_pkg::PROGRAMMING_INTERFACE_FIELD_BRIDGE; // see R3
      rev_reg <= pcm_pkg::REV_RESET; // see R13
    end else if (ce) begin
      if (ee_load) begin
        base_reg <= ee_class_word[pcm_pkg::BASE_POS +: 8]; // see R13
        sub_reg <= ee_class_word[pcm_pkg::SUB_POS +: 8];
        programming_interface_field_reg <= ee_class_word[pcm_pkg::PROGRAMMING_INTERFACE_FIELD_POS +: 8];
        rev_reg <= ee_class_word[pcm_pkg::REV_POS +: 8];
      end
      if (pb_hit_class) begin
        if (pb_be[3]) begin
          base_reg <= pb_wdata[pcm_pkg::BASE_POS +: 8]; // see R5
        end
        if (pb_be[2]) begin
          sub_reg <= pb_wdata[pcm_pkg::SUB_POS +: 8];
        end
        if (pb_be[1]) begin
          programming_interface_field_reg <= pb_wdata[pcm_pkg::PROGRAMMING_INTERFACE_FIELD_POS +: 8];
        end
        if (pb_be[0]) begin
          rev_reg <= pb_wdata[pcm_pkg::REV_POS +: 8];
        end
      end
    end
  end

  // Misc word: timer and line size writable from both sides, processor last
  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      master_latency_timer_reg <= pcm_pkg::MASTER_LATENCY_TIMER_RESET; // see R13
      cacheline_size_field_reg <= pcm_pkg::CACHELINE_SIZE_FIELD_RESET;
    end else if (ce) begin
      if (cfg_hit_misc && cfg_be[1]) begin
        master_latency_timer_reg <= cfg_wdata[pcm_pkg::MASTER_LATENCY_TIMER_POS +: 8];
      end
      if (cfg_hit_misc && cfg_be[0]) begin
        cacheline_size_field_reg <= cfg_wdata[pcm_pkg::CACHELINE_SIZE_FIELD_POS +: 8];
      end
      if (pb_hit_misc && pb_be[1]) begin
        master_latency_timer_reg <= pb_wdata[pcm_pkg::MASTER_LATENCY_TIMER_POS +: 8];
      end
      if (pb_hit_misc && pb_be[0]) begin
        cacheline_size_field_reg <= pb_wdata[pcm_pkg::CACHELINE_SIZE_FIELD_POS +: 8];
      end
    end
  end

  assign class_word = {base_reg, sub_reg, programming_interface_field_reg, rev_reg}; // see R14
  // Self-test, multifunction and layout bits are constant zero
  assign misc_word = {16'h0000, master_latency_timer_reg, cacheline_size_field_reg}; // see R6 see R7

  // Shell offsets are only meaningful with the controller class pair
  assign controller_mode = (base_reg == pcm_pkg::BASE_CONTROLLER)
                        && (programming_interface_field_reg == pcm_pkg::PROGRAMMING_INTERFACE_FIELD_CONTROLLER); // see R3 see R4

  // ****************************************************************
  // Read ports
  // ****************************************************************
  function automatic logic [31:0] pcm_read_word(input logic [7:0] addr,
                                                input logic [31:0] cls,
                                                input logic [31:0] misc);
    logic [31:0] word;
    word = 32'h0000_0000;
    if (addr == pcm_pkg::CLASS_WORD_OFS) begin
      word = cls;
    end else if (addr == pcm_pkg::MISC_WORD_OFS) begin
      word = misc;
    end
    return word;
  endfunction : pcm_read_word

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (ce && cfg_rd) begin
      cfg_rdata <= pcm_read_word(cfg_addr, class_word, misc_word); // see R14
    end
  end

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pb_rdata <= 32'h0000_0000;
    end else if (ce && pb_rd) begin
      pb_rdata <= pcm_read_word(pb_addr, class_word, misc_word);
    end
  end

  // ****************************************************************
  // Cacheline decode and read command
  // ****************************************************************
  logic [5:0] line_words;
  logic [15:0] line_bytes;

  always_comb begin
    if (cacheline_size_field_reg == pcm_pkg::CACHELINE_SIZE_FIELD_4W) begin
      line_words = 6'h04; // see R10
    end else if (cacheline_size_field_reg == pcm_pkg::CACHELINE_SIZE_FIELD_16W) begin
      line_words = 6'h10;
    end else if (cacheline_size_field_reg == pcm_pkg::CACHELINE_SIZE_FIELD_32W) begin
      line_words = 6'h20;
    end else begin
      line_words = 6'h08; // see R11
    end
  end

  assign cacheline_words = line_words;
  assign line_bytes = {8'h00, line_words, 2'b00};

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mst_read_cmd <= pcm_pkg::PCM_CMD_MEM_READ;
    end else if (ce && mst_req) begin
      if (mst_read_bytes < pcm_pkg::SHORT_READ_BYTES) begin
        mst_read_cmd <= pcm_pkg::PCM_CMD_MEM_READ; // see R12
      end else if (mst_read_bytes <= line_bytes) begin
        mst_read_cmd <= pcm_pkg::PCM_CMD_MEM_READ_LINE;
      end else begin
        mst_read_cmd <= pcm_pkg::PCM_CMD_MEM_READ_MULT;
      end
    end
  end

  // ****************************************************************
  // Latency timer
  // ****************************************************************
  pcm_latency_timer u_latency_timer (
    .clock(clock),
    .rst_n(rst_n_reg),
    .ce(ce),
    .run(mst_owner),
    .timer_value(master_latency_timer_reg),
    .expired(mst_lt_expired)
  );

  // ****************************************************************
  // Check helpers
  // ****************************************************************
  // Owner cycles counted apart from the timer, so expiry is judged on its own
  logic [7:0] owner_cycles_reg;

  always_ff @(posedge clock or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      owner_cycles_reg <= 8'h00;
    end else if (ce) begin
      if (!mst_owner) begin
        owner_cycles_reg <= 8'h00;
      end else if (owner_cycles_reg != 8'hFF) begin
        owner_cycles_reg <= owner_cycles_reg + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_reg || !ce);

  a_class_reset_val: assert property ($rose(rst_n_reg) |-> class_word == 32'h0680_005A) // see R1
    else $error("class word not at reset value after release");
  a_sub_reset_val: assert property ($rose(rst_n_reg) |-> sub_reg == 8'h80 && programming_interface_field_reg == 8'h00) // see R2
    else $error("sub class or programming_interface_field interface wrong after reset");
  a_ctrl_mode_flag: assert property (controller_mode |-> base_reg == 8'h0E && programming_interface_field_reg == 8'h01) // see R3
    else $error("controller mode without controller class");
  a_ctrl_offsets: assert property (base_reg == 8'h0E && programming_interface_field_reg == 8'h01
                                   |-> controller_mode) // see R4
    else $error("controller class pair without controller mode");
  a_class_pci_ro: assert property (cfg_wr && !pb_wr && !ee_load |=> $stable(class_word)) // see R5
    else $error("class word changed by PCI write");
  a_selftest_capable_bit_reads_zero: assert property (cfg_rd && cfg_addr == 8'h0C |=> cfg_rdata[31:24] == 8'h00) // see R6
    else $error("self-test byte not zero");
  a_layout_reads_zero: assert property (pb_rd && pb_addr == 8'h0C |=> pb_rdata[23:16] == 8'h00) // see R7
    else $error("header layout byte not zero");
  a_lt_floor: assert property ($rose(mst_owner) |-> !mst_lt_expired [*8]) // see R9
    else $error("latency timer expired before eight clocks");
  a_lt_expiry: assert property (mst_owner && master_latency_timer_reg >= 8'h08 && owner_cycles_reg == master_latency_timer_reg
                                |-> mst_lt_expired) // see R8
    else $error("latency timer did not expire at its setting");
  a_lt_not_early: assert property (mst_owner && owner_cycles_reg < master_latency_timer_reg
                                   |-> !mst_lt_expired) // see R8
    else $error("latency timer expired before its setting");
  a_cmd_hold: assert property (!mst_req |=> $stable(mst_read_cmd)) // see R12
    else $error("read command changed without a request");
  a_cfg_rdata_hold: assert property (!cfg_rd |=> $stable(cfg_rdata)) // see R14
    else $error("config read data changed without a read");
  a_pb_rdata_hold: assert property (!pb_rd |=> $stable(pb_rdata)) // see R14
    else $error("processor read data changed without a read");
  a_class_pb_write: assert property (pb_hit_class && pb_be == 4'hF
                                     |=> class_word == $past(pb_wdata)) // see R5
    else $error("processor write to class word not applied");
  a_cacheline_size_field_valid: assert property (cacheline_size_field_reg == 8'h20 |-> cacheline_words == 6'h20) // see R10
    else $error("32-word cacheline not decoded");
  a_cacheline_size_field_default: assert property (!(cacheline_size_field_reg inside {8'h04, 8'h10, 8'h20})
                                    |-> cacheline_words == 6'h08) // see R11
    else $error("invalid cacheline code not eight words");
  a_cmd_short: assert property (mst_req && mst_read_bytes < 16'h0008
                                |=> mst_read_cmd == 4'b0110) // see R12
    else $error("short read not Memory Read");
  a_cmd_multi: assert property (mst_req && mst_read_bytes > line_bytes && mst_read_bytes >= 16'h0008
                                |=> mst_read_cmd == 4'b1100) // see R12
    else $error("long read not Memory Read Multiple");
  a_ee_overwrite: assert property (ee_load && !pb_wr |=> class_word == $past(ee_class_word)) // see R13
    else $error("EEPROM load not applied");
  a_rev_readback: assert property (cfg_rd && cfg_addr == 8'h08 |=> cfg_rdata[7:0] == $past(rev_reg)) // see R14
    else $error("revision not in low byte of class read");

  c_ee_load: cover property (ee_load ##1 controller_mode);
  c_line_read: cover property (mst_req ##1 mst_read_cmd == 4'b1110);
  c_lt_expire: cover property (mst_lt_expired);
  c_pci_misc_write: cover property (cfg_hit_misc ##1 cfg_rd);
  c_lt_floor_hit: cover property (mst_owner && master_latency_timer_reg < 8'h08 && mst_lt_expired);

endmodule : pcm_config_regs

// ### verilog/pcm_pkg.sv
// Constants for the class and miscellaneous configuration words of the first PCI port.
// Assumes a single 100 MHz clock and byte addresses within PCI configuration space.
package pcm_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] CLASS_WORD_OFS = 8'h08;
  localparam logic [7:0] MISC_WORD_OFS = 8'h0C;

  // ****************************************************************
  // Field positions (low bit of each field)
  // ****************************************************************
  localparam int BASE_POS = 24;
  localparam int SUB_POS = 16;
  localparam int PROGRAMMING_INTERFACE_FIELD_POS = 8;
  localparam int REV_POS = 0;
  localparam int MASTER_LATENCY_TIMER_POS = 8;
  localparam int CACHELINE_SIZE_FIELD_POS = 0;

  // ****************************************************************
  // Reset values and controller-mode class values
  // ****************************************************************
  localparam logic [7:0] BASE_BRIDGE = 8'h06;
  localparam logic [7:0] BASE_CONTROLLER = 8'h0E;
  localparam logic [7:0] SUB_OTHER_BRIDGE = 8'h80;
  localparam logic [7:0] SUB_CONTROLLER = 8'h00;
  localparam logic [7:0] PROGRAMMING_INTERFACE_FIELD_BRIDGE = 8'h00;
  localparam logic [7:0] PROGRAMMING_INTERFACE_FIELD_CONTROLLER = 8'h01;
  // Arbitrary neutral revision value
  localparam logic [7:0] REV_RESET = 8'h5A;
  localparam logic [7:0] MASTER_LATENCY_TIMER_RESET = 8'h00;
  localparam logic [7:0] CACHELINE_SIZE_FIELD_RESET = 8'h00;

  // ****************************************************************
  // Controller-mode shell offsets
  // ****************************************************************
  localparam logic [7:0] INBOUND_QUEUE_OFS = 8'h40;
  localparam logic [7:0] OUTBOUND_QUEUE_OFS = 8'h44;
  localparam logic [7:0] HOST_INT_STATUS_OFS = 8'h30;
  localparam logic [7:0] HOST_INT_MASK_OFS = 8'h34;

  // ****************************************************************
  // Cacheline codes and master read timing
  // ****************************************************************
  localparam logic [7:0] CACHELINE_SIZE_FIELD_4W = 8'h04;
  localparam logic [7:0] CACHELINE_SIZE_FIELD_8W = 8'h08;
  localparam logic [7:0] CACHELINE_SIZE_FIELD_16W = 8'h10;
  localparam logic [7:0] CACHELINE_SIZE_FIELD_32W = 8'h20;
  localparam logic [15:0] SHORT_READ_BYTES = 16'h0008;
  localparam logic [7:0] MASTER_LATENCY_TIMER_MIN_CLOCKS = 8'h08;

  typedef enum logic [3:0] {
    PCM_CMD_MEM_READ = 4'b0110,
    PCM_CMD_MEM_READ_MULT = 4'b1100,
    PCM_CMD_MEM_READ_LINE = 4'b1110
  } pcm_read_cmd_t;

endpackage : pcm_pkg

// ### verilog/pcm_latency_timer.sv
// Master latency timer: counts PCI clocks while the master owns the bus.
// Assumes synchronous reset copy and clock enable from the parent.
`timescale 1ns/1ps
module pcm_latency_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic [7:0] timer_value,
  output logic expired
);

  logic [7:0] count_reg;
  logic [7:0] limit;

  // Low settings are lifted to the floor of eight clocks
  assign limit = (timer_value < pcm_pkg::MASTER_LATENCY_TIMER_MIN_CLOCKS) ? pcm_pkg::MASTER_LATENCY_TIMER_MIN_CLOCKS
                                                           : timer_value; // see R9

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 8'h00;
    end else if (ce) begin
      if (!run) begin
        count_reg <= 8'h00;
      end else if (count_reg != limit) begin
        count_reg <= count_reg + 8'h01; // see R8
      end
    end
  end

  // Master starts termination once the count reaches the limit
  assign expired = run && (count_reg == limit); // see R8

endmodule : pcm_latency_timer

// ### verification/pcm_pci_host.sv
// PCI host model: configuration reads and writes on the block's cfg port.
// Assumes one caller at a time and a free-running clock.
`timescale 1ns/1ps
module pcm_pci_host (
  input wire logic clock,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata
);
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h00000000;
  end

  // Host reaches only through config cycles, never the processor side
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clock);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_wr <= 1'b0;
    // Released data is scrambled so a stale value cannot pass
    cfg_wdata <= ~d;
    // Return once the write has settled, so callers never race the edge
    #1;
  endtask : cfg_write

  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_rd <= 1'b0;
    #1;
    d = cfg_rdata;
  endtask : cfg_read
endmodule : pcm_pci_host

// ### verification/tb_top.sv
// Bench for the class and misc config words: one task per scenario.
// Assumes the design package, design modules and host model compile first.
`timescale 1ns/1ps
module tb_top;
  logic clock, arst_n = 1'b0, pb_wr = 1'b0, pb_rd = 1'b0, ee_load = 1'b0;
  logic mst_req = 1'b0, mst_owner = 1'b0, mst_lt_expired, controller_mode;
  logic cfg_wr, cfg_rd;
  logic [7:0] cfg_addr, pb_addr = 8'h00;
  logic [3:0] cfg_be, pb_be = 4'hF, mst_read_cmd;
  logic [31:0] cfg_wdata, cfg_rdata, pb_wdata = 32'h0, pb_rdata, ee_class_word = 32'h0, rd;
  logic [15:0] mst_read_bytes = 16'h0;
  logic [5:0] cacheline_words;
  logic [31:0] cls_rst;
  int n_errors = 0, samples_checked = 0, cycles = 0;

  pcm_config_regs dut_u (.clock, .arst_n, .ce(1'b1), .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
    .cfg_wdata, .cfg_rdata, .pb_wr, .pb_rd, .pb_addr, .pb_be, .pb_wdata, .pb_rdata, .ee_load,
    .ee_class_word, .mst_req, .mst_read_bytes, .mst_read_cmd, .mst_owner, .mst_lt_expired,
    .cacheline_words, .controller_mode);
  pcm_pci_host host_u (.clock, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata);

  assign cls_rst = {8'h06, 8'h80, 8'h00, pcm_pkg::REV_RESET};

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ****
  // Checks and bus tasks
  // ****
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic pb_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    pb_wr <= wr;
    pb_rd <= !wr;
    pb_addr <= a;
    pb_wdata <= d;
    @(posedge clock);
    pb_wr <= 1'b0;
    pb_rd <= 1'b0;
    pb_wdata <= ~d;
    #1;
  endtask : pb_access

  task automatic mst_read(input logic [15:0] n, input logic [3:0] exp);
    @(posedge clock);
    mst_req <= 1'b1;
    mst_read_bytes <= n;
    @(posedge clock);
    mst_req <= 1'b0;
    #1;
    chk8({4'h0, mst_read_cmd}, {4'h0, exp});
  endtask : mst_read

  task automatic check_reset_words();
    host_u.cfg_read(pcm_pkg::CLASS_WORD_OFS, rd);
    chk32(rd, cls_rst);
    host_u.cfg_read(pcm_pkg::MISC_WORD_OFS, rd);
    chk32(rd, 32'h00000000);
    chk8({2'h0, cacheline_words}, 8'h08);
    chk8({7'h00, controller_mode}, 8'h00);
  endtask : check_reset_words

  // ****
  // Scenarios
  // ****
  task automatic t_pci_writes();
    host_u.cfg_write(8'h08, 4'hF, 32'hFFFFFFFF);
    host_u.cfg_write(8'h0C, 4'hF, 32'hFFFFFFFF);
    host_u.cfg_read(8'h08, rd);
    chk32(rd, cls_rst);
    host_u.cfg_read(8'h0C, rd);
    chk32(rd, 32'h0000FFFF);
    chk8({2'h0, cacheline_words}, 8'h08);
    host_u.cfg_write(8'h0C, 4'h1, 32'h00000A10);
    host_u.cfg_read(8'h0C, rd);
    chk32(rd, 32'h0000FF10);
    host_u.cfg_write(8'h10, 4'hF, 32'hFFFFFFFF);
    host_u.cfg_read(8'h10, rd);
    chk32(rd, 32'h00000000);
  endtask : t_pci_writes

  task automatic t_class_load();
    pb_access(1'b1, 8'h08, {8'h0E, 8'h00, 8'h01, 8'h22});
    chk8({7'h00, controller_mode}, 8'h01);
    host_u.cfg_read(8'h08, rd);
    chk32(rd, 32'h0E000122);
    pb_access(1'b0, 8'h08, 32'h0);
    chk32(pb_rdata, 32'h0E000122);
    @(posedge clock);
    ee_class_word <= 32'h06800033;
    ee_load <= 1'b1;
    @(posedge clock);
    ee_load <= 1'b0;
    host_u.cfg_read(8'h08, rd);
    chk32(rd, 32'h06800033);
    chk8({7'h00, controller_mode}, 8'h00);
  endtask : t_class_load

  task automatic t_cacheline_cmd();
    logic [7:0] codes [7] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h00, 8'h07, 8'h40};
    logic [7:0] words [7] = '{8'd4, 8'd8, 8'd16, 8'd32, 8'd8, 8'd8, 8'd8};
    for (int i = 0; i < 7; i++) begin
      host_u.cfg_write(8'h0C, 4'h1, {24'h0, codes[i]});
      chk8({2'h0, cacheline_words}, words[i]);
      mst_read(16'd7, pcm_pkg::PCM_CMD_MEM_READ);
      mst_read({6'h0, words[i], 2'b00}, pcm_pkg::PCM_CMD_MEM_READ_LINE);
      mst_read({6'h0, words[i], 2'b00} + 16'd4, pcm_pkg::PCM_CMD_MEM_READ_MULT);
    end
    mst_read(16'd8, pcm_pkg::PCM_CMD_MEM_READ_LINE);
  endtask : t_cacheline_cmd

  task automatic t_latency(input logic [7:0] v);
    int lim;
    lim = (v < 8'd8) ? 8 : int'(v);
    host_u.cfg_write(8'h0C, 4'h2, {16'h0, v, 8'h0});
    @(posedge clock);
    mst_owner <= 1'b1;
    for (int k = 0; k <= lim; k++) begin
      #1;
      chk8({7'h00, mst_lt_expired}, {7'h00, k == lim});
      @(posedge clock);
    end
    mst_owner <= 1'b0;
    #1;
    chk8({7'h00, mst_lt_expired}, 8'h00);
  endtask : t_latency

  task automatic t_reset_mid();
    host_u.cfg_write(8'h0C, 4'hF, 32'h00001234);
    pb_access(1'b1, 8'h08, 32'h0E000101);
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check_reset_words();
  endtask : t_reset_mid

  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // Ceiling is over a hundred times the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check_reset_words();
    t_pci_writes();
    t_class_load();
    t_cacheline_cmd();
    t_latency(8'h03);
    t_latency(8'h0C);
    t_reset_mid();
    report_and_stop();
  end
endmodule : tb_top
